// >>> inc/rtc_pkg.sv
// Constants, register numbers, field positions and carrier types of the indexed real time clock.
// Assumes a single 40 MHz system clock and host I/O cycles presented as one-cycle strobes.
package rtc_pkg;

  // ----------------------------------------------------------------------
  // Host I/O port addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_PORT_ADDR = 16'h0070; // Register selector port.
  localparam logic [15:0] DATA_PORT_ADDR = 16'h0071; // Register data port.

  // ----------------------------------------------------------------------
  // Internal register numbers
  // ----------------------------------------------------------------------
  localparam logic [6:0] REG_SEC = 7'h00; // Seconds.
  localparam logic [6:0] REG_ALM_SEC = 7'h01; // Alarm seconds (general byte).
  localparam logic [6:0] REG_MIN = 7'h02; // Minutes.
  localparam logic [6:0] REG_ALM_MIN = 7'h03; // Alarm minutes (general byte).
  localparam logic [6:0] REG_HOUR = 7'h04; // Hours.
  localparam logic [6:0] REG_ALM_HOUR = 7'h05; // Alarm hours (general byte).
  localparam logic [6:0] REG_WDAY = 7'h06; // Weekday, 1 is Sunday.
  localparam logic [6:0] REG_DOM = 7'h07; // Day of month.
  localparam logic [6:0] REG_MON = 7'h08; // Month.
  localparam logic [6:0] REG_YEAR = 7'h09; // Year within the century.
  localparam logic [6:0] REG_A = 7'h0a; // Time base and rate control.
  localparam logic [6:0] REG_B = 7'h0b; // Interrupt and format control.
  localparam logic [6:0] REG_C = 7'h0c; // Interrupt flags.
  localparam logic [6:0] REG_D = 7'h0d; // Validity and alarm day.

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int A_UIP_BIT = 7; // Update in progress.
  localparam int A_DIV_LSB = 4; // Divider field, bits 6 to 4.
  localparam int B_SET_BIT = 7; // Inhibit update.
  localparam int B_PIE_BIT = 6; // Periodic interrupt enable.
  localparam int B_AIE_BIT = 5; // Alarm interrupt enable.
  localparam int B_UIE_BIT = 4; // Update-ended interrupt enable.
  localparam int B_DM_BIT = 2; // Data mode, 1 is binary.
  localparam int B_24H_BIT = 1; // Hours format, 1 is 24 hour.
  localparam int B_DSE_BIT = 0; // Daylight saving adjust.
  localparam int C_IRQF_BIT = 7; // Interrupt asserted flag.
  localparam int D_VRT_BIT = 7; // Valid time flag.
  localparam logic [2:0] DIV_NORMAL = 3'h2; // Divider pattern that lets time run.
  localparam logic [1:0] ALM_DONT_CARE = 2'h3; // Alarm byte top bits meaning any value.

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_RESET = 8'h26; // Divider 010, periodic rate 6.
  localparam logic [7:0] B_RESET = 8'h02; // BCD, 24 hour, all interrupts off.
  localparam logic [7:0] DAY_RESET = 8'h01; // Day, month and weekday start at one.

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40000000; // System clock rate.
  localparam int BASE_HZ = 32768; // Time base rate.
  localparam int SEC_TICKS = 32768; // Time base ticks per second.
  localparam int UIP_LEAD = 8; // Ticks of update-in-progress before each update.

  // Clock and calendar bytes, kept in the format that software selected.
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] dom;
    logic [7:0] mon;
    logic [7:0] year;
  } calendar_t;

  // One host I/O cycle.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_t;

endpackage : rtc_pkg

// >>> core/rtc_core.sv
// Indexed real time clock with calendar, alarm, periodic and update-ended interrupt flags.
// Assumes host I/O strobes are synchronous to CLOCK_IN and last one cycle each.
`timescale 1ns/1ps

// Contract
// - Selector port at 70h holds register 00h-7Fh
// - Data port at 71h reads/writes selected register
// - Time and date at 00h through 09h
// - A bit 7 flags update in progress
// - A bits 3-0 choose periodic rate
// - B bit 7 stops clock advance
// - B bit 6 enables periodic interrupt
// - B bit 5 enables alarm interrupt
// - B bit 4 enables update-ended interrupt
// - B bit 3 has no effect
// - B bit 2 selects BCD or binary
// - B bit 1 selects 12 or 24 hours
// - B bit 0 enables daylight saving adjust
// - C bit 7 set by enabled condition
// - C bits 6-4 record conditions regardless
// - Reading C clears all its flags
// - D bit 7 always reads one
// - D bits 5-0 hold alarm day
module rtc_core #(
  parameter int CLK_HZ = rtc_pkg::CLK_HZ,
  parameter int BASE_HZ = rtc_pkg::BASE_HZ,
  parameter int SEC_TICKS = rtc_pkg::SEC_TICKS
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  // Host I/O cycle
  input wire logic [15:0] IO_ADDR_IN,
  input wire logic IO_WR_IN,
  input wire logic IO_RD_IN,
  input wire logic [7:0] IO_WDATA_IN,
  // Host answer and interrupt
  output logic [7:0] IO_RDATA_OUT,
  output logic IRQ_OUT
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (CLK_HZ < 2 * BASE_HZ || BASE_HZ < 1)
    $error("Clock must be at least twice the time base.");
  if (SEC_TICKS < rtc_pkg::UIP_LEAD + 2 || SEC_TICKS > 32768)
    $error("Ticks per second out of range.");

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Converts a stored byte to binary.
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    if (bin)
      return v;
    return 8'(v[7:4] * 4'ha) + {4'h0, v[3:0]};
  endfunction : to_bin

  // Converts a binary value below 100 to the stored format.
  function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
    if (bin)
      return v;
    return {4'(v / 8'h0a), 4'(v % 8'h0a)};
  endfunction : from_bin

  // Days in a month; every fourth year is a leap year.
  function automatic logic [7:0] month_days(input logic [7:0] mo, input logic [7:0] yr);
    case (mo)
      8'h02: return (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: return 8'h1e;
      default: return 8'h1f;
    endcase
  endfunction : month_days

  // Alarm byte matches when equal or when its top bits say any value.
  function automatic logic alarm_hit(input logic [7:0] alm, input logic [7:0] cur);
    return (alm[7:6] == rtc_pkg::ALM_DONT_CARE) || (alm == cur);
  endfunction : alarm_hit

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_reg; // First stage of the release chain.
  logic rst_n; // Released reset used by the rest of the block.

  // Assertion comes at once, release waits two clock edges.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Host port decode
  // ----------------------------------------------------------------------
  rtc_pkg::io_req_t req; // Bundled host cycle.
  logic [6:0] idx_reg; // Selected register number.
  logic dat_wr; // Write to the data port.
  logic dat_rd; // Read of the data port.
  logic c_read; // Read of the flag register, which clears it.

  assign req = '{rd: IO_RD_IN, wr: IO_WR_IN, addr: IO_ADDR_IN, wdata: IO_WDATA_IN};
  assign dat_wr = req.wr && (req.addr == rtc_pkg::DATA_PORT_ADDR);
  assign dat_rd = req.rd && (req.addr == rtc_pkg::DATA_PORT_ADDR);
  assign c_read = dat_rd && (idx_reg == rtc_pkg::REG_C);

  // Selector port keeps the register number; bit 7 of the write is dropped.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      idx_reg <= 7'h00;
    else if (req.wr && req.addr == rtc_pkg::IDX_PORT_ADDR)
      idx_reg <= req.wdata[6:0];
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [6:0] a_reg; // Divider and rate bits; the busy bit is live state.
  logic [7:0] b_reg; // Enables and formats; bit 3 is stored and unused.
  logic [5:0] alarm_day_reg; // Alarm day of month.
  logic [7:0] ram_reg [128]; // General bytes, including alarm time.

  // Writes through the data port to control bytes and general storage.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_reg <= rtc_pkg::A_RESET[6:0];
      b_reg <= rtc_pkg::B_RESET;
      alarm_day_reg <= 6'h00;
      for (int i = 0; i < 128; i++)
        ram_reg[i] <= 8'h00;
    end
    else if (dat_wr)
    begin
      case (idx_reg)
        rtc_pkg::REG_A: a_reg <= req.wdata[6:0];
        rtc_pkg::REG_B: b_reg <= req.wdata;
        rtc_pkg::REG_D: alarm_day_reg <= req.wdata[5:0];
        default: ram_reg[idx_reg] <= req.wdata;
      endcase
    end
  end

  logic inhibit; // Update inhibited by software.
  logic bin_mode; // Binary rather than BCD.
  logic h24_mode; // 24-hour rather than 12-hour.
  logic [3:0] rate; // Periodic rate select.
  logic div_run; // Divider set to its running pattern.

  assign inhibit = b_reg[rtc_pkg::B_SET_BIT];
  assign bin_mode = b_reg[rtc_pkg::B_DM_BIT];
  assign h24_mode = b_reg[rtc_pkg::B_24H_BIT];
  assign rate = a_reg[3:0];
  assign div_run = a_reg[6:4] == rtc_pkg::DIV_NORMAL;

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  logic [31:0] acc_reg; // Fractional accumulator for the time base.
  logic [31:0] acc_sum; // Accumulator plus one step.
  logic base_tick; // One-cycle time base enable.
  logic [14:0] sub_reg; // Ticks within the current second.
  logic sec_tick; // Last tick of a second.
  logic uip_reg; // Update in progress.

  assign acc_sum = acc_reg + 32'(BASE_HZ);
  assign base_tick = acc_sum >= 32'(CLK_HZ);
  assign sec_tick = base_tick && div_run && (sub_reg == 15'(SEC_TICKS - 1));

  // Accumulator spreads base ticks evenly over the system clock.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      acc_reg <= 32'h0;
    else if (base_tick)
      acc_reg <= acc_sum - 32'(CLK_HZ);
    else
      acc_reg <= acc_sum;
  end

  // Sub-second count is held at zero while the divider is not running.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      sub_reg <= 15'h0;
    else if (!div_run)
      sub_reg <= 15'h0;
    else if (sec_tick)
      sub_reg <= 15'h0;
    else if (base_tick)
      sub_reg <= sub_reg + 15'h1;
  end

  // Busy flag rises a few ticks ahead of each update and falls with it.
  // It ignores the inhibit bit so that an update right after the inhibit is
  // lifted still had its lead; the read path hides it while inhibited.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      uip_reg <= 1'b0;
    else
      uip_reg <= div_run && !sec_tick &&
        (sub_reg >= 15'(SEC_TICKS - rtc_pkg::UIP_LEAD));
  end

  // ----------------------------------------------------------------------
  // Calendar advance
  // ----------------------------------------------------------------------
  rtc_pkg::calendar_t cal_reg; // Current time and date.
  rtc_pkg::calendar_t cal_adv; // Time and date one second later.
  rtc_pkg::calendar_t cal_next; // Value taken at the next edge.
  logic advance; // Seconds advance this cycle.
  logic fall_done_reg; // Autumn hour repeat already taken this year.
  logic spring_now; // Spring forward applies to this advance.
  logic fall_now; // Autumn fall back applies to this advance.

  assign advance = sec_tick && !inhibit;

  // Works in binary, then returns to the selected formats.
  always_comb
  begin
    logic [7:0] s;
    logic [7:0] m;
    logic [7:0] h;
    logic [7:0] w;
    logic [7:0] d;
    logic [7:0] mo;
    logic [7:0] y;
    logic [7:0] h12;
    h12 = 8'h00;
    s = to_bin(cal_reg.sec, bin_mode);
    m = to_bin(cal_reg.min, bin_mode);
    h = to_bin({1'b0, cal_reg.hour[6:0]}, bin_mode);
    w = to_bin(cal_reg.wday, bin_mode);
    d = to_bin(cal_reg.dom, bin_mode);
    mo = to_bin(cal_reg.mon, bin_mode);
    y = to_bin(cal_reg.year, bin_mode);
    // A 12-hour value carries noon and midnight as 12 and PM in bit 7.
    if (!h24_mode)
      h = ((h == 8'h0c) ? 8'h00 : h) + (cal_reg.hour[7] ? 8'h0c : 8'h00);
    spring_now = b_reg[rtc_pkg::B_DSE_BIT] && mo == 8'h04 && w == 8'h01 && d <= 8'h07 &&
      h == 8'h01 && m == 8'h3b && s == 8'h3b;
    fall_now = b_reg[rtc_pkg::B_DSE_BIT] && !fall_done_reg && mo == 8'h0a && w == 8'h01 &&
      d >= 8'h19 && h == 8'h01 && m == 8'h3b && s == 8'h3b;
    if (s < 8'h3b)
      s = s + 8'h01;
    else
    begin
      s = 8'h00;
      if (m < 8'h3b)
        m = m + 8'h01;
      else
      begin
        m = 8'h00;
        if (h < 8'h17)
          h = h + 8'h01;
        else
        begin
          h = 8'h00;
          w = (w >= 8'h07) ? 8'h01 : w + 8'h01;
          if (d < month_days(mo, y))
            d = d + 8'h01;
          else
          begin
            d = 8'h01;
            if (mo < 8'h0c)
              mo = mo + 8'h01;
            else
            begin
              mo = 8'h01;
              y = (y >= 8'h63) ? 8'h00 : y + 8'h01;
            end
          end
        end
      end
    end
    // Daylight saving moves the hour after 01:59:59 on the switch days.
    if (spring_now)
      h = 8'h03;
    else if (fall_now)
      h = 8'h01;
    h12 = from_bin((h % 8'h0c == 8'h00) ? 8'h0c : h % 8'h0c, bin_mode);
    cal_adv.sec = from_bin(s, bin_mode);
    cal_adv.min = from_bin(m, bin_mode);
    cal_adv.hour = h24_mode ? from_bin(h, bin_mode) :
      {h >= 8'h0c, h12[6:0]};
    cal_adv.wday = from_bin(w, bin_mode);
    cal_adv.dom = from_bin(d, bin_mode);
    cal_adv.mon = from_bin(mo, bin_mode);
    cal_adv.year = from_bin(y, bin_mode);
  end

  // A host write replaces one field on top of any advance in the same cycle.
  always_comb
  begin
    cal_next = advance ? cal_adv : cal_reg;
    if (dat_wr)
    begin
      case (idx_reg)
        rtc_pkg::REG_SEC: cal_next.sec = req.wdata;
        rtc_pkg::REG_MIN: cal_next.min = req.wdata;
        rtc_pkg::REG_HOUR: cal_next.hour = req.wdata;
        rtc_pkg::REG_WDAY: cal_next.wday = req.wdata;
        rtc_pkg::REG_DOM: cal_next.dom = req.wdata;
        rtc_pkg::REG_MON: cal_next.mon = req.wdata;
        rtc_pkg::REG_YEAR: cal_next.year = req.wdata;
        default: cal_next = cal_next;
      endcase
    end
  end

  // Time and date storage.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      cal_reg <= '{sec: 8'h00, min: 8'h00, hour: 8'h00, wday: rtc_pkg::DAY_RESET,
        dom: rtc_pkg::DAY_RESET, mon: rtc_pkg::DAY_RESET, year: 8'h00};
    else
      cal_reg <= cal_next;
  end

  // The autumn repeat is taken once, then rearmed outside October.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      fall_done_reg <= 1'b0;
    else if (advance && fall_now)
      fall_done_reg <= 1'b1;
    else if (to_bin(cal_reg.mon, bin_mode) != 8'h0a)
      fall_done_reg <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Interrupt conditions and flags
  // ----------------------------------------------------------------------
  logic per_ev; // Periodic condition.
  logic alm_ev; // Alarm condition.
  logic upd_ev; // Update-ended condition.
  logic [15:0] rate_mask; // Sub-second bits that must all be set.
  logic [2:0] flags_reg; // Periodic, alarm and update-ended flags.
  logic irqf_reg; // Interrupt asserted flag.
  logic [2:0] flags_next; // Flags for the next edge.
  logic [2:0] enables; // Matching enables from the control byte.

  assign rate_mask = 16'((32'h1 << (rate - 4'h1)) - 32'h1);
  assign per_ev = base_tick && div_run && rate != 4'h0 &&
    (({1'b0, sub_reg} & rate_mask) == rate_mask);
  assign upd_ev = advance;
  assign alm_ev = advance && alarm_hit(ram_reg[rtc_pkg::REG_ALM_SEC], cal_adv.sec) &&
    alarm_hit(ram_reg[rtc_pkg::REG_ALM_MIN], cal_adv.min) &&
    alarm_hit(ram_reg[rtc_pkg::REG_ALM_HOUR], cal_adv.hour) &&
    (alarm_day_reg == 6'h00 || alarm_day_reg == cal_adv.dom[5:0]);
  assign enables = b_reg[rtc_pkg::B_PIE_BIT:rtc_pkg::B_UIE_BIT];
  // A new condition in the reading cycle survives the clear.
  assign flags_next = (c_read ? 3'h0 : flags_reg) | {per_ev, alm_ev, upd_ev};

  // Condition flags are recorded whatever the enables say.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= 3'h0;
    else
      flags_reg <= flags_next;
  end

  // Interrupt flag follows enabled conditions and drives the output.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      irqf_reg <= 1'b0;
    else
      irqf_reg <= (c_read ? 1'b0 : irqf_reg) |
        (|({per_ev, alm_ev, upd_ev} & enables));
  end

  assign IRQ_OUT = irqf_reg;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] rd_val; // Byte presented for the current read.

  // Selects the byte for the port being read.
  always_comb
  begin
    rd_val = 8'h00;
    if (req.addr == rtc_pkg::IDX_PORT_ADDR)
      rd_val = {1'b0, idx_reg};
    else
    begin
      case (idx_reg)
        rtc_pkg::REG_SEC: rd_val = cal_reg.sec;
        rtc_pkg::REG_MIN: rd_val = cal_reg.min;
        rtc_pkg::REG_HOUR: rd_val = cal_reg.hour;
        rtc_pkg::REG_WDAY: rd_val = cal_reg.wday;
        rtc_pkg::REG_DOM: rd_val = cal_reg.dom;
        rtc_pkg::REG_MON: rd_val = cal_reg.mon;
        rtc_pkg::REG_YEAR: rd_val = cal_reg.year;
        rtc_pkg::REG_A: rd_val = {uip_reg && !inhibit, a_reg};
        rtc_pkg::REG_B: rd_val = b_reg;
        rtc_pkg::REG_C: rd_val = {irqf_reg, flags_reg, 4'h0};
        rtc_pkg::REG_D: rd_val = {1'b1, 1'b0, alarm_day_reg};
        default: rd_val = ram_reg[idx_reg];
      endcase
    end
  end

  // Read data is registered and held until the next read.
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      IO_RDATA_OUT <= 8'h00;
    else if (req.rd && (req.addr == rtc_pkg::IDX_PORT_ADDR || dat_rd))
      IO_RDATA_OUT <= rd_val;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!rst_n);

  chk_index_capture: assert property (
    req.wr && req.addr == rtc_pkg::IDX_PORT_ADDR |=> idx_reg == $past(req.wdata[6:0]))
    else $error("Selector did not take the written number.");
  chk_valid_bit_read: assert property (
    dat_rd && idx_reg == rtc_pkg::REG_D |=> IO_RDATA_OUT[7:6] == 2'h2)
    else $error("Register D valid bit or reserved bit wrong.");
  chk_flag_read_clear: assert property (
    c_read && !per_ev && !alm_ev && !upd_ev |=> flags_reg == 3'h0 && !IRQ_OUT)
    else $error("Reading C did not clear its flags.");
  chk_inhibit_hold: assert property (
    inhibit && !dat_wr |=> cal_reg == $past(cal_reg))
    else $error("Clock advanced while inhibited.");
  chk_periodic_irq: assert property (
    per_ev && b_reg[rtc_pkg::B_PIE_BIT] |=> IRQ_OUT && flags_reg[2])
    else $error("Enabled periodic condition did not raise the interrupt.");
  chk_alarm_flag: assert property (
    alm_ev && !b_reg[rtc_pkg::B_AIE_BIT] |=> flags_reg[1])
    else $error("Alarm flag not set while disabled.");
  chk_irq_cause: assert property (
    $rose(IRQ_OUT) |-> $past(|({per_ev, alm_ev, upd_ev} & enables)))
    else $error("Interrupt rose without an enabled condition.");
  chk_second_step: assert property (
    advance && !dat_wr |=> cal_reg.sec != $past(cal_reg.sec) && flags_reg[0])
    else $error("Seconds did not advance at the update.");
  chk_busy_before: assert property (
    advance |-> uip_reg ##1 !uip_reg)
    else $error("Busy flag not high before the update.");

endmodule : rtc_core

// >>> sim/host_model.sv
// Host processor model that makes indexed register cycles on the I/O port.
// Assumes the device shares its clock; lines change at falling edges only.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk_in,
  // I/O cycle toward the device
  output logic [15:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  // Answer from the device
  input wire logic [7:0] rdata_in
);
  // Idle lines at time zero, no strobe.
  initial
  begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end

  // One strobe cycle; released lines show the inverse of the last value.
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    q = rdata_in;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : cyc

  // Listed registers only; the selector is always written first.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    cyc(16'h0070, 1'b1, idx, q);
    cyc(16'h0071, 1'b1, d, q);
  endtask : wr

  // Read of one listed register through the selector.
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    cyc(16'h0070, 1'b1, idx, q);
    cyc(16'h0071, 1'b0, 8'h00, q);
  endtask : rd
endmodule : host_model

// >>> sim/testbench.sv
// Self-checking bench for the indexed clock with shortened time base.
// Assumes the host model drives every I/O input of the device.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] q;
  logic [7:0] d;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'hc5e7;
  int exp_reg[int]; // Model of register contents by index.
  int idx_tab[6] = '{0, 2, 4, 7, 8, 9}; // Time and date bytes.
  int val_tab[6] = '{'h59, 'h59, 'h23, 'h31, 'h12, 'h99}; // Last second of a century.
  int dst_idx[6] = '{6, 7, 8, 4, 2, 0}; // Weekday, day, month, hour, minute, second.
  int dst_val[6] = '{1, 1, 4, 1, 'h3b, 'h3b}; // Binary 01:59:59 on a spring switch day.

  rtc_core #(.CLK_HZ(8), .BASE_HZ(4), .SEC_TICKS(16)) DUT (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .IO_ADDR_IN(addr), .IO_WR_IN(wr), .IO_RD_IN(rd), .IO_WDATA_IN(wdata),
    .IO_RDATA_OUT(rdata), .IRQ_OUT(irq));
  host_model host (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata), .rdata_in(rdata));

  initial forever #12.5 clk = ~clk;

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] idx, input string name, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(idx, v);
    chk(name, exp, v);
  endtask : rdchk

  // Waits a bounded time for the interrupt line.
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    chk("irq_out", 8'h01, {7'h00, irq});
  endtask : wait_irq

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    rdchk(8'h0d, "reg_d", 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      host.wr(8'h0d, d);
      exp_reg[13] = {2'b10, d[5:0]};
      rdchk(8'h0d, "alarm_day", exp_reg[13][7:0]);
    end
    host.wr(8'h8d, 8'h00);
    host.cyc(16'h0070, 1'b0, 8'h00, q);
    chk("selector", 8'h0d, q);
    host.wr(8'h0a, 8'h20);
    host.rd(8'h0c, q);
    host.wr(8'h0b, 8'h12);
    wait_irq();
    rdchk(8'h0c, "flags_upd", 8'h90);
    rdchk(8'h0c, "flags_clr", 8'h00);
    host.wr(8'h0b, 8'h82);
    foreach (idx_tab[i]) host.wr(idx_tab[i][7:0], val_tab[i][7:0]);
    repeat (100) @(negedge clk);
    rdchk(8'h00, "held_sec", 8'h59);
    host.rd(8'h0c, q);
    host.wr(8'h0b, 8'h12);
    wait_irq();
    rdchk(8'h0c, "flags_alarm", 8'hb0);
    foreach (idx_tab[i]) rdchk(idx_tab[i][7:0], "rollover", (i > 2 && i < 5) ? 8'h01 : 8'h00);
    host.wr(8'h0a, 8'h23);
    host.wr(8'h0b, 8'h8a);
    host.rd(8'h0c, q);
    repeat (20) @(negedge clk);
    chk("irq_masked", 8'h00, {7'h00, irq});
    rdchk(8'h0a, "busy_masked", 8'h23);
    rdchk(8'h0c, "flags_per", 8'h40);
    host.wr(8'h0b, 8'hc2);
    wait_irq();
    rdchk(8'h0c, "flags_pie", 8'hc0);
    host.wr(8'h0b, 8'h87);
    host.rd(8'h0c, q);
    foreach (dst_idx[i]) host.wr(dst_idx[i][7:0], dst_val[i][7:0]);
    host.wr(8'h0b, 8'h17);
    wait_irq();
    rdchk(8'h04, "dst_hour", 8'h03);
    host.wr(8'h0b, 8'h80);
    host.rd(8'h0c, q);
    host.wr(8'h04, 8'h91);
    host.wr(8'h02, 8'h59);
    host.wr(8'h00, 8'h59);
    host.wr(8'h0b, 8'h10);
    wait_irq();
    rdchk(8'h04, "hour_12h", 8'h12);
    tally_and_finish();
  end
endmodule : testbench
